// File: hw/pll_clock_select_ctrl.sv
// pll clock selection block: post divider, bus clock source switch, reset cause
// flags, oscillator spike filter and qualification, fallback on lost qualification.
// assumes vco, oscillator and lock inputs are synchronous to clk and much slower.
// clocks appear as one-cycle ticks of clk, one tick per rising source edge.
//
// Operation
// - divider write only while pll selected
// - locked pll clock is vco over divider+1
// - unlocked pll clock is vco over four
// - pll-sourced bus clock is pll over two
// - power-on flag set by por, kept over system reset
// - low-voltage flag set by lvr or por
// - illegal-address flag set, cleared by por
// - bypass mode takes bus clock from oscillator
// - oscillator enable feeds oscillator as pll reference
// - vco-clocked spike filter qualifies oscillator clock
// - watchdog and tick clocks selectable in bypass
// - lost lock clears oscillator qualified status
// - lost qualification forces pll select back
// - lock and qualified status sampled on bus clock
// - filter pauses oscillator-sourced bus clock after disturbance until settled
`timescale 1ns/10ps
module pll_clock_select_ctrl #(
  parameter int DIV_W = 5,
  parameter int CNT_W = 8
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       power_on_reset,
  input  wire logic       low_voltage_reset,
  input  wire logic       illegal_address_reset,
  input  wire logic       vco_clock,
  input  wire logic       oscillator_clock,
  input  wire logic       pll_lock,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            pll_clock_tick,
  output logic            bus_clock_tick,
  output logic            bus_from_oscillator,
  output logic            pll_reference_oscillator,
  output logic            watchdog_clock_oscillator,
  output logic            periodic_tick_clock_oscillator,
  output logic            oscillator_enable,
  output logic            irq
);

  localparam int RAT_W = DIV_W + 1;

  typedef struct packed {
    logic [DIV_W-1:0]                          pll_output_divider;
    logic                                      pll_source_select;
    logic                                      osc_enable;
    logic                                      filter_enable;
    logic                                      wdog_osc;
    logic                                      tick_osc;
    logic [pll_clock_select_pkg::FIL_VALUE_W-1:0] spike_filter_value;
    logic                                      spike_filter_bandwidth;
    logic                                      power_on_reset_flag;
    logic                                      low_voltage_reset_flag;
    logic                                      illegal_address_reset_flag;
    logic                                      lock_chg;
    logic                                      osc_chg;
    logic [pll_clock_select_pkg::FLG_STICKY_W-1:0] irq_enable;
    logic                                      lock_status;
    logic                                      qual_status;
    logic                                      vco_prev;
    logic                                      osc_prev;
    logic [CNT_W-1:0]                          interval;
    logic [CNT_W-1:0]                          edge_cnt;
    pll_clock_select_pkg::qual_state_t         qstate;
    pll_clock_select_pkg::mux_state_t          mstate;
    logic                                      bus_tick;
    logic                                      bus_osc;
    logic                                      wdog_out;
    logic                                      tick_out;
    logic [7:0]                                rdata;
    logic                                      irq;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  logic             pll_tick;
  logic             pll_bus_tick;
  logic [RAT_W-1:0] pll_ratio;
  logic             div_nrst;

  // por also restarts the dividers, since it implies a system reset
  assign div_nrst = nrst & ~power_on_reset;

  // post divider ratio follows lock without waiting for the bus clock
  assign pll_ratio = pll_lock ? (RAT_W'(st_r.pll_output_divider) + RAT_W'(1))
                              : RAT_W'(pll_clock_select_pkg::UNLOCKED_RATIO);

  edge_ratio_divider #(
    .W (RAT_W)
  ) u_pll_div (
    .clk      (clk),
    .nrst     (div_nrst),
    .src_tick (st_nxt.vco_prev & ~st_r.vco_prev),
    .ratio    (pll_ratio),
    .tick     (pll_tick)
  );

  edge_ratio_divider #(
    .W (2)
  ) u_bus_div (
    .clk      (clk),
    .nrst     (div_nrst),
    .src_tick (pll_tick),
    .ratio    (pll_clock_select_pkg::BUS_RATIO[1:0]),
    .tick     (pll_bus_tick)
  );

  // main next-state logic
  always_comb begin
    logic                                         vco_edge;
    logic                                         osc_edge;
    logic                                         spike;
    logic                                         filt_tick;
    logic                                         qualified;
    logic                                         wr_hit;
    logic [pll_clock_select_pkg::FIL_VALUE_W-1:0] tol;
    logic [pll_clock_select_pkg::FIL_VALUE_W-1:0] min_int;
    logic [pll_clock_select_pkg::FLG_STICKY_W-1:0] sticky;
    logic [pll_clock_select_pkg::FLG_STICKY_W-1:0] clr;
    vco_edge  = 1'b0;
    osc_edge  = 1'b0;
    spike     = 1'b0;
    filt_tick = 1'b0;
    qualified = 1'b0;
    wr_hit    = 1'b0;
    tol       = '0;
    min_int   = '0;
    sticky    = '0;
    clr       = '0;
    st_nxt    = st_r;

    // edge detection on the sampled source clocks
    st_nxt.vco_prev = vco_clock;
    st_nxt.osc_prev = oscillator_clock & st_r.osc_enable;
    vco_edge = vco_clock & ~st_r.vco_prev;
    osc_edge = st_nxt.osc_prev & ~st_r.osc_prev;

    // interval between oscillator edges, measured in vco edges
    if (osc_edge) begin
      st_nxt.interval = '0;
    end else if (vco_edge && (st_r.interval != '1)) begin
      st_nxt.interval = st_r.interval + CNT_W'(1);
    end

    // wider bandwidth tolerates more jitter before an edge counts as a spike
    tol     = st_r.spike_filter_bandwidth ? (st_r.spike_filter_value >> 2)
                                          : (st_r.spike_filter_value >> 3);
    min_int = st_r.spike_filter_value - tol;
    spike   = st_r.filter_enable & osc_edge & (st_r.interval < CNT_W'(min_int));

    // oscillator qualification: oscillator edges qualify, vco edges time the settling pause
    unique case (st_r.qstate)
      pll_clock_select_pkg::Q_OFF: begin
        st_nxt.edge_cnt = '0;
        st_nxt.qstate   = pll_clock_select_pkg::Q_START;
      end
      pll_clock_select_pkg::Q_START: begin
        if (spike) begin
          st_nxt.edge_cnt = '0;
        end else if (osc_edge) begin
          st_nxt.edge_cnt = st_r.edge_cnt + CNT_W'(1);
          if (st_r.edge_cnt == CNT_W'(pll_clock_select_pkg::QUAL_EDGES - 8'h01)) begin
            st_nxt.qstate = pll_clock_select_pkg::Q_QUAL;
          end
        end
      end
      pll_clock_select_pkg::Q_QUAL: begin
        if (spike) begin
          // the disturbance is swallowed, qualified status stays high
          st_nxt.edge_cnt = '0;
          st_nxt.qstate   = pll_clock_select_pkg::Q_PAUSE;
        end else begin
          filt_tick = osc_edge;
        end
      end
      pll_clock_select_pkg::Q_PAUSE: begin
        if (spike) begin
          st_nxt.edge_cnt = '0;
        end else if (vco_edge) begin
          st_nxt.edge_cnt = st_r.edge_cnt + CNT_W'(1);
          if (st_r.edge_cnt == CNT_W'(pll_clock_select_pkg::SETTLE_VCO_EDGES - 8'h01)) begin
            st_nxt.qstate = pll_clock_select_pkg::Q_QUAL;
          end
        end
      end
    endcase
    if (!st_r.osc_enable || !pll_lock) begin
      st_nxt.qstate = pll_clock_select_pkg::Q_OFF;
    end
    qualified = pll_lock & st_r.osc_enable &
                ((st_r.qstate == pll_clock_select_pkg::Q_QUAL) ||
                 (st_r.qstate == pll_clock_select_pkg::Q_PAUSE));

    // status bits only move on a bus clock tick; a pause still counts as qualified, so pauses go unreported
    if (st_r.bus_tick) begin
      st_nxt.lock_status = pll_lock;
      st_nxt.qual_status = qualified;
    end

    // register writes
    wr_hit = reg_wr;
    if (wr_hit && (reg_addr == pll_clock_select_pkg::OFS_OUTPUT_DIVIDER) &&
        st_r.pll_source_select) begin
      st_nxt.pll_output_divider = reg_wdata[DIV_W-1:0];
    end
    if (wr_hit && (reg_addr == pll_clock_select_pkg::OFS_FLAGS_CLEAR)) begin
      clr = reg_wdata[pll_clock_select_pkg::FLG_STICKY_W-1:0];
    end
    if (wr_hit && (reg_addr == pll_clock_select_pkg::OFS_IRQ_ENABLE)) begin
      st_nxt.irq_enable = reg_wdata[pll_clock_select_pkg::FLG_STICKY_W-1:0];
    end
    if (wr_hit && (reg_addr == pll_clock_select_pkg::OFS_CLOCK_CTRL)) begin
      st_nxt.pll_source_select = reg_wdata[pll_clock_select_pkg::CTL_PLL_SELECT_BIT];
      st_nxt.osc_enable        = reg_wdata[pll_clock_select_pkg::CTL_OSC_ENABLE_BIT];
      st_nxt.filter_enable     = reg_wdata[pll_clock_select_pkg::CTL_FILTER_EN_BIT];
      st_nxt.wdog_osc          = reg_wdata[pll_clock_select_pkg::CTL_WDOG_OSC_BIT];
      st_nxt.tick_osc          = reg_wdata[pll_clock_select_pkg::CTL_TICK_OSC_BIT];
    end
    if (wr_hit && (reg_addr == pll_clock_select_pkg::OFS_FILTER)) begin
      st_nxt.spike_filter_value =
        reg_wdata[pll_clock_select_pkg::FIL_VALUE_LSB +: pll_clock_select_pkg::FIL_VALUE_W];
      st_nxt.spike_filter_bandwidth = reg_wdata[pll_clock_select_pkg::FIL_BANDWIDTH_BIT];
    end

    // hardware fallback wins over a software write in the same cycle
    if (!st_r.pll_source_select && !qualified) begin
      st_nxt.pll_source_select = 1'b1;
    end

    // sticky flags: a set in the clearing cycle survives the clear
    st_nxt.power_on_reset_flag        = st_r.power_on_reset_flag &
                                        ~clr[pll_clock_select_pkg::FLG_POWER_ON_BIT];
    st_nxt.low_voltage_reset_flag     = (st_r.low_voltage_reset_flag &
                                        ~clr[pll_clock_select_pkg::FLG_LOW_VOLTAGE_BIT]) |
                                        low_voltage_reset;
    st_nxt.illegal_address_reset_flag = (st_r.illegal_address_reset_flag &
                                        ~clr[pll_clock_select_pkg::FLG_ILLEGAL_BIT]) |
                                        illegal_address_reset;
    st_nxt.lock_chg = (st_r.lock_chg & ~clr[pll_clock_select_pkg::FLG_LOCK_CHG_BIT]) |
                      (st_nxt.lock_status ^ st_r.lock_status);
    st_nxt.osc_chg  = (st_r.osc_chg & ~clr[pll_clock_select_pkg::FLG_OSC_CHG_BIT]) |
                      (st_nxt.qual_status ^ st_r.qual_status);

    // bus clock source switch; the new source's first tick is dropped so the
    // gap after switching is never shorter than a full period of the new source
    st_nxt.bus_tick = 1'b0;
    unique case (st_r.mstate)
      pll_clock_select_pkg::M_PLL: begin
        st_nxt.bus_tick = pll_bus_tick;
        if (!st_r.pll_source_select) begin
          st_nxt.bus_tick = 1'b0;
          st_nxt.mstate   = pll_clock_select_pkg::M_TO_OSC;
        end
      end
      pll_clock_select_pkg::M_TO_OSC: begin
        if (st_r.pll_source_select) begin
          st_nxt.mstate = pll_clock_select_pkg::M_TO_PLL;
        end else if (filt_tick) begin
          st_nxt.mstate = pll_clock_select_pkg::M_OSC;
        end
      end
      pll_clock_select_pkg::M_OSC: begin
        st_nxt.bus_tick = filt_tick;
        if (st_r.pll_source_select) begin
          st_nxt.bus_tick = 1'b0;
          st_nxt.mstate   = pll_clock_select_pkg::M_TO_PLL;
        end
      end
      pll_clock_select_pkg::M_TO_PLL: begin
        if (pll_bus_tick) begin
          st_nxt.mstate = pll_clock_select_pkg::M_PLL;
        end
      end
    endcase

    // source levels registered here so each output port comes from a flop
    st_nxt.bus_osc  = st_nxt.mstate == pll_clock_select_pkg::M_OSC;
    st_nxt.wdog_out = st_nxt.wdog_osc & ~st_nxt.pll_source_select;
    st_nxt.tick_out = st_nxt.tick_osc & ~st_nxt.pll_source_select;

    // read port: data stand only in the cycle after the strobe
    sticky = {st_r.osc_chg, st_r.lock_chg, st_r.illegal_address_reset_flag,
              st_r.low_voltage_reset_flag, st_r.power_on_reset_flag};
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        pll_clock_select_pkg::OFS_OUTPUT_DIVIDER: begin
          st_nxt.rdata = 8'(st_r.pll_output_divider);
        end
        pll_clock_select_pkg::OFS_FLAGS: begin
          st_nxt.rdata = {1'b0, st_r.qual_status, st_r.lock_status, sticky};
        end
        pll_clock_select_pkg::OFS_IRQ_ENABLE: begin
          st_nxt.rdata = 8'(st_r.irq_enable);
        end
        pll_clock_select_pkg::OFS_CLOCK_CTRL: begin
          st_nxt.rdata = {3'h0, st_r.tick_osc, st_r.wdog_osc, st_r.filter_enable,
                          st_r.osc_enable, st_r.pll_source_select};
        end
        pll_clock_select_pkg::OFS_FILTER: begin
          st_nxt.rdata = {st_r.spike_filter_bandwidth, 2'h0, st_r.spike_filter_value};
        end
        default: begin
          st_nxt.rdata = 8'h00; // clear register is write-only, others unmapped
        end
      endcase
    end

    st_nxt.irq = |(sticky & st_r.irq_enable);
  end

  // state register; reset-cause flags survive a system reset, only power-on touches them
  always_ff @(posedge clk) begin
    if (power_on_reset) begin
      st_r                            <= '0;
      st_r.pll_output_divider         <= pll_clock_select_pkg::OUTPUT_DIVIDER_RST[DIV_W-1:0];
      st_r.pll_source_select          <= pll_clock_select_pkg::CLOCK_CTRL_RST[0];
      st_r.spike_filter_value         <= pll_clock_select_pkg::FILTER_RST[4:0];
      st_r.irq_enable                 <= pll_clock_select_pkg::IRQ_ENABLE_RST[4:0];
      st_r.qstate                     <= pll_clock_select_pkg::Q_OFF;
      st_r.mstate                     <= pll_clock_select_pkg::M_PLL;
      st_r.power_on_reset_flag        <= 1'b1;
      st_r.low_voltage_reset_flag     <= 1'b1;
      st_r.illegal_address_reset_flag <= 1'b0;
    end else if (!nrst) begin
      st_r                            <= '0;
      st_r.pll_output_divider         <= pll_clock_select_pkg::OUTPUT_DIVIDER_RST[DIV_W-1:0];
      st_r.pll_source_select          <= pll_clock_select_pkg::CLOCK_CTRL_RST[0];
      st_r.spike_filter_value         <= pll_clock_select_pkg::FILTER_RST[4:0];
      st_r.irq_enable                 <= pll_clock_select_pkg::IRQ_ENABLE_RST[4:0];
      st_r.qstate                     <= pll_clock_select_pkg::Q_OFF;
      st_r.mstate                     <= pll_clock_select_pkg::M_PLL;
      st_r.power_on_reset_flag        <= st_r.power_on_reset_flag;
      st_r.low_voltage_reset_flag     <= st_r.low_voltage_reset_flag;
      st_r.illegal_address_reset_flag <= st_r.illegal_address_reset_flag;
    end else begin
      st_r <= st_nxt;
    end
  end

  // output taps, all straight from state flip-flops
  assign reg_rdata                      = st_r.rdata;
  assign pll_clock_tick                 = pll_tick;
  assign bus_clock_tick                 = st_r.bus_tick;
  assign bus_from_oscillator            = st_r.bus_osc;
  assign pll_reference_oscillator       = st_r.osc_enable;
  assign watchdog_clock_oscillator      = st_r.wdog_out;
  assign periodic_tick_clock_oscillator = st_r.tick_out;
  assign oscillator_enable              = st_r.osc_enable;
  assign irq                            = st_r.irq;

endmodule : pll_clock_select_ctrl

// File: hw/pll_clock_select_pkg.sv
// package for the pll clock selection block: register map, field layout,
// reset values and counts of the oscillator qualification logic.
// assumes an 8-bit register port and one system clock sampling all clock inputs.
package pll_clock_select_pkg;

  // register offsets
  localparam logic [7:0] OFS_OUTPUT_DIVIDER = 8'h00;
  localparam logic [7:0] OFS_FLAGS          = 8'h01;
  localparam logic [7:0] OFS_FLAGS_CLEAR    = 8'h02;
  localparam logic [7:0] OFS_IRQ_ENABLE     = 8'h03;
  localparam logic [7:0] OFS_CLOCK_CTRL     = 8'h04;
  localparam logic [7:0] OFS_FILTER         = 8'h05;

  // flag register layout; the same layout serves clear and enable
  localparam int FLG_POWER_ON_BIT    = 0;
  localparam int FLG_LOW_VOLTAGE_BIT = 1;
  localparam int FLG_ILLEGAL_BIT     = 2;
  localparam int FLG_LOCK_CHG_BIT    = 3;
  localparam int FLG_OSC_CHG_BIT     = 4;
  localparam int FLG_LOCK_BIT        = 5;
  localparam int FLG_QUALIFIED_BIT   = 6;
  localparam int FLG_STICKY_W        = 5;

  // clock control layout
  localparam int CTL_PLL_SELECT_BIT  = 0;
  localparam int CTL_OSC_ENABLE_BIT  = 1;
  localparam int CTL_FILTER_EN_BIT   = 2;
  localparam int CTL_WDOG_OSC_BIT    = 3;
  localparam int CTL_TICK_OSC_BIT    = 4;

  // filter register layout
  localparam int FIL_VALUE_LSB       = 0;
  localparam int FIL_VALUE_W         = 5;
  localparam int FIL_BANDWIDTH_BIT   = 7;

  // reset values
  localparam logic [7:0] OUTPUT_DIVIDER_RST = 8'h03;
  localparam logic [7:0] CLOCK_CTRL_RST     = 8'h01;
  localparam logic [7:0] FILTER_RST         = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST     = 8'h00;

  // ratios and counts
  localparam logic [7:0] UNLOCKED_RATIO  = 8'h04;
  localparam logic [7:0] BUS_RATIO       = 8'h02;
  localparam logic [7:0] QUAL_EDGES      = 8'h10;
  localparam logic [7:0] SETTLE_VCO_EDGES = 8'h20;

  // oscillator qualification states
  typedef enum logic [3:0] {
    Q_OFF   = 4'h1,
    Q_START = 4'h2,
    Q_QUAL  = 4'h4,
    Q_PAUSE = 4'h8
  } qual_state_t;

  // bus clock source switch states
  typedef enum logic [3:0] {
    M_PLL    = 4'h1,
    M_TO_OSC = 4'h2,
    M_OSC    = 4'h4,
    M_TO_PLL = 4'h8
  } mux_state_t;

endpackage : pll_clock_select_pkg

// File: hw/edge_ratio_divider.sv
// edge ratio divider: emits one tick for every 'ratio' source ticks.
// assumes source ticks are one-cycle pulses of the system clock.
`timescale 1ns/10ps
module edge_ratio_divider #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         src_tick,
  input  wire logic [W-1:0] ratio,
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  // a ratio of zero behaves as one, so the divider can never stall
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (src_tick) begin
      if ((st_r.cnt + W'(1)) >= ratio) begin
        st_nxt.cnt  = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : edge_ratio_divider

// File: sim/pll_clock_select_ctrl_properties.sv
// checker for the pll clock selection block: port-level timing relations.
// assumes it is bound to the block's top module and sees only its ports.
`timescale 1ns/10ps
module pll_clock_select_checker (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       power_on_reset,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pll_clock_tick,
  input wire logic       bus_clock_tick,
  input wire logic       bus_from_oscillator,
  input wire logic       pll_reference_oscillator,
  input wire logic       watchdog_clock_oscillator,
  input wire logic       periodic_tick_clock_oscillator,
  input wire logic       oscillator_enable,
  input wire logic       irq
);
  // either reset source silences the checks; por resets everything too
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || power_on_reset);

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_pll_tick_single: assert property (pll_clock_tick |=> !pll_clock_tick)
    else $error("pll tick longer than one cycle");
  a_bus_tick_single: assert property (bus_clock_tick |=> !bus_clock_tick)
    else $error("bus tick longer than one cycle");
  // a pll-sourced bus tick follows a pll tick by two cycles: divider flop, then mux flop
  a_bus_half_pll: assert property (bus_clock_tick && !bus_from_oscillator |-> $past(pll_clock_tick, 2))
    else $error("pll bus tick without preceding pll tick");
  a_ref_follows_en: assert property (pll_reference_oscillator == oscillator_enable)
    else $error("pll reference differs from oscillator enable");
  a_osc_entry_enabled: assert property ($rose(bus_from_oscillator) |-> oscillator_enable)
    else $error("bus moved to oscillator while oscillator disabled");
  a_reset_clock_src: assert property (!$past(nrst) |-> !watchdog_clock_oscillator
      && !periodic_tick_clock_oscillator && !bus_from_oscillator && !oscillator_enable)
    else $error("clock source outputs not at reset value");
  a_irq_reset_low: assert property (!$past(nrst) |-> !irq)
    else $error("interrupt high right after reset");

  c_enter_bypass: cover property ($rose(bus_from_oscillator));
  c_fallback: cover property ($fell(bus_from_oscillator));
  c_irq_raised: cover property ($rose(irq));
endmodule : pll_clock_select_checker

bind pll_clock_select_ctrl pll_clock_select_checker chk_u (.clk(clk), .nrst(nrst),
  .power_on_reset(power_on_reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pll_clock_tick(pll_clock_tick), .bus_clock_tick(bus_clock_tick),
  .bus_from_oscillator(bus_from_oscillator), .pll_reference_oscillator(pll_reference_oscillator),
  .watchdog_clock_oscillator(watchdog_clock_oscillator),
  .periodic_tick_clock_oscillator(periodic_tick_clock_oscillator),
  .oscillator_enable(oscillator_enable), .irq(irq));

// File: sim/pll_clock_select_ctrl_tb_top.sv
// self-checking bench for the pll clock selection block.
// assumes vco and oscillator are slow square waves made here in the clk domain.
`timescale 1ns/10ps
module pll_clock_select_ctrl_tb_top;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic       clk, nrst, power_on_reset, low_voltage_reset, illegal_address_reset;
  logic       vco_clock, oscillator_clock, pll_lock, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
  logic       pll_clock_tick, bus_clock_tick, bus_from_oscillator, irq;
  logic       pll_reference_oscillator, watchdog_clock_oscillator;
  logic       periodic_tick_clock_oscillator, oscillator_enable;
  int         error_cnt = 0, tests_run = 0, cyc = 0, n;
  // address, write data, read-back expected
  row_t       rows [7] = '{'{8'h00, 8'he5, 8'h05}, '{8'h03, 8'hff, 8'h1f},
    '{8'h05, 8'hff, 8'h9f}, '{8'h04, 8'h1d, 8'h1d}, '{8'h04, 8'h01, 8'h01},
    '{8'h10, 8'hab, 8'h00}, '{8'h02, 8'h1f, 8'h00}};

  pll_clock_select_ctrl dut_u (.clk(clk), .nrst(nrst), .power_on_reset(power_on_reset),
    .low_voltage_reset(low_voltage_reset), .illegal_address_reset(illegal_address_reset),
    .vco_clock(vco_clock), .oscillator_clock(oscillator_clock), .pll_lock(pll_lock),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pll_clock_tick(pll_clock_tick), .bus_clock_tick(bus_clock_tick),
    .bus_from_oscillator(bus_from_oscillator), .pll_reference_oscillator(pll_reference_oscillator),
    .watchdog_clock_oscillator(watchdog_clock_oscillator),
    .periodic_tick_clock_oscillator(periodic_tick_clock_oscillator),
    .oscillator_enable(oscillator_enable), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // vco period 4 cycles, oscillator period 6 cycles; both well under clk/2
  always @(posedge clk) begin
    cyc <= cyc + 1;
    vco_clock <= (cyc % 4) >= 2;
    oscillator_clock <= (cyc % 6) >= 3;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the read edge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // two syncs absorb a ratio change mid-count, the third span is measured
  task period(input bit b, output int p);
    repeat (3) begin
      p = 0;
      do begin
        @(posedge clk);
        #1 p++;
      end while (!(b ? bus_clock_tick : pll_clock_tick) && p < 400);
    end
  endtask : period

  task wait_bus(input logic v);
    int k;
    k = 0;
    while (bus_from_oscillator !== v && k < 200) begin
      @(posedge clk);
      #1 k++;
    end
    check(bus_from_oscillator, v);
  endtask : wait_bus

  task close_out;
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // cuts a hang short; the whole sequence needs well under 6000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial begin
    {nrst, low_voltage_reset, illegal_address_reset, reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata} = '0;
    power_on_reset = 1'b1;
    pll_lock = 1'b1;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    power_on_reset <= 1'b0;
    rd(8'h00, r); check(r, pll_clock_select_pkg::OUTPUT_DIVIDER_RST);
    rd(8'h04, r); check(r, pll_clock_select_pkg::CLOCK_CTRL_RST);
    rd(8'h05, r); check(r, pll_clock_select_pkg::FILTER_RST);
    rd(8'h03, r); check(r, pll_clock_select_pkg::IRQ_ENABLE_RST);
    rd(8'h01, r); check(r & 8'h07, 8'h03);
    // illegal-address event, then a system reset must keep all cause flags
    @(posedge clk) illegal_address_reset <= 1'b1;
    @(posedge clk) illegal_address_reset <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h01, r); check(r & 8'h07, 8'h07);
    wr(8'h02, 8'h07);
    @(posedge clk) low_voltage_reset <= 1'b1;
    @(posedge clk) low_voltage_reset <= 1'b0;
    rd(8'h01, r); check(r & 8'h07, 8'h02);
    @(posedge clk) power_on_reset <= 1'b1;
    @(posedge clk) power_on_reset <= 1'b0;
    rd(8'h01, r); check(r & 8'h07, 8'h03);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, r);
      check(r, rows[i].e);
    end
    wr(8'h03, 8'h00);
    // locked ratios: pll = vco / (d+1), bus = pll / 2
    for (int d = 0; d < 5; d += 2) begin
      wr(8'h00, 8'(d));
      period(0, n); check(16'(n), 16'(4 * (d + 1)));
      period(1, n); check(16'(n), 16'(8 * (d + 1)));
    end
    // bypass entry in the documented software order
    wr(8'h00, 8'h01);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h03);
    repeat (300) @(posedge clk);
    rd(8'h01, r); check(r & 8'h60, 8'h60);
    wr(8'h02, 8'h1f);
    rd(8'h01, r); check(r & 8'h1f, 8'h00);
    wr(8'h03, 8'h08);
    wr(8'h04, 8'h1a);
    wait_bus(1'b1);
    check({watchdog_clock_oscillator, periodic_tick_clock_oscillator}, 2'b11);
    check({pll_reference_oscillator, oscillator_enable}, 2'b11);
    period(1, n); check(16'(n), 16'd6);
    wr(8'h00, 8'h07);
    rd(8'h00, r); check(r, 8'h01);
    check(irq, 1'b0);
    // lock loss drops qualification and forces the pll back
    @(posedge clk) pll_lock <= 1'b0;
    wait_bus(1'b0);
    rd(8'h04, r); check(r & 8'h01, 8'h01);
    check(watchdog_clock_oscillator, 1'b0);
    period(0, n); check(16'(n), 16'd16);
    // also lets bus ticks resume, so the status bits see the lost lock
    period(1, n); check(16'(n), 16'd32);
    rd(8'h01, r); check(r & 8'h48, 8'h08);
    check(irq, 1'b1);
    wr(8'h03, 8'h00);
    repeat (2) @(posedge clk);
    #1 check(irq, 1'b0);
    wr(8'h03, 8'h08);
    repeat (2) @(posedge clk);
    #1 check(irq, 1'b1);
    wr(8'h02, 8'h1f);
    repeat (2) @(posedge clk);
    #1 check(irq, 1'b0);
    // filter on: every oscillator edge comes sooner than the minimum interval
    @(posedge clk) pll_lock <= 1'b1;
    wr(8'h05, 8'h04);
    wr(8'h04, 8'h07);
    repeat (300) @(posedge clk);
    rd(8'h01, r); check(r & 8'h40, 8'h00);
    wr(8'h05, 8'h00);
    repeat (300) @(posedge clk);
    rd(8'h01, r); check(r & 8'h40, 8'h40);
    close_out();
  end
endmodule : pll_clock_select_ctrl_tb_top
